//--- rtl/dcc_defs.svh
// Functional notes
// - Async reset clears calibration state immediately
// - Tracking enable holds time-mode delay constant
// - Raise delay_calibrated after fixed-line calibration
// - All three status outputs readable in registers
// - Raise tracking_ready after baseline drift calibration
// - Compensate drift continuously after baseline
// - tracking_ready holds until reset or disable
// - Register port runs on the APB clock pclk
// - Six-bit address selects bits next cycle
// - Read data appears one cycle later
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ****************************************
// APB register map (byte addresses)
// ****************************************
`define DCC_REG_CTRL      12'h000
`define DCC_REG_STATUS    12'h004
`define DCC_REG_PORT_ADDR 12'h008
`define DCC_REG_PORT_WDAT 12'h00C
`define DCC_REG_PORT_RDAT 12'h010
`define DCC_REG_DRIFT     12'h014

// ****************************************
// Field positions and reset values
// ****************************************
`define DCC_CTRL_TRACK_BIT  0
`define DCC_CTRL_CAL_BIT    1
`define DCC_CTRL_RESET      2'h0
`define DCC_STAT_DLY_BIT    0
`define DCC_STAT_TRK_BIT    1
`define DCC_STAT_OK_BIT     2
`define DCC_RIU_STAT_ADDR   6'h00
`define DCC_RIU_DRIFT_ADDR  6'h01
`define DCC_ONE16           16'h0001

// ****************************************
// Calibration timing
// ****************************************
`define DCC_CLK_MHZ         25
`define DCC_FIX_CAL_NS      2000
`define DCC_VT_CAL_NS       4000
`define DCC_FIX_CAL_CYC     ((`DCC_FIX_CAL_NS * `DCC_CLK_MHZ + 999) / 1000)
`define DCC_VT_CAL_CYC      ((`DCC_VT_CAL_NS * `DCC_CLK_MHZ + 999) / 1000)
`define DCC_TRACK_PERIOD    16
`define DCC_COLL_CYC        3

`endif

//--- rtl/dcc_pkg.sv
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_IDLE  = 2'b00,
    DCC_FIXED = 2'b01,
    DCC_VT    = 2'b10,
    DCC_TRACK = 2'b11
  } dcc_cal_e;

  typedef struct packed {
    logic        dly;
    logic        trk;
  } dcc_stat_s;
endpackage : dcc_pkg

//--- rtl/dcc_top.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dcc_defs.svh"

module dcc_top
  import dcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status outputs
  output logic             delay_calibrated,
  output logic             tracking_ready,
  output logic             regport_access_ok
);

  // ****************************************
  // State
  // ****************************************
  dcc_cal_e           state, next_state;
  logic [CNT_W-1:0]   cnt, next_cnt;
  logic               drift_tracking_enable, next_drift_tracking_enable;
  logic               cal_start, next_cal_start;
  logic [5:0]         regport_address, next_regport_address;
  logic [15:0]        regport_read_bus, next_regport_read_bus;
  logic [15:0]        drift_code, next_drift_code;
  logic [15:0]        next_drift_code_fab;
  logic [15:0]        shadow, next_shadow;
  logic [1:0]         coll, next_coll;
  logic               pend, next_pend;
  logic               dly_q, next_dly_q;
  logic               trk_q, next_trk_q;
  logic               ok_q, next_ok_q;
  logic [31:0]        next_prdata;
  logic               next_pready;
  logic               next_pslverr;
  dcc_stat_s          st;

  // Word read of an internal register, by address
  function automatic logic [15:0] riu_read(input logic [5:0] a, input dcc_stat_s s,
                                            input logic [15:0] d);
    if (a == `DCC_RIU_STAT_ADDR) begin
      riu_read = {14'h0000, s.trk, s.dly};
    end else if (a == `DCC_RIU_DRIFT_ADDR) begin
      riu_read = d;
    end else begin
      riu_read = 16'h0000;
    end
  endfunction : riu_read

  assign st.dly = dly_q;
  assign st.trk = trk_q;

  wire apb_setup = psel && !penable;
  // Writes land only at the access edge that samples pready high
  wire apb_wr    = psel && penable && pready && pwrite;
  // Engine writes the drift register on every tracking tick
  wire eng_wr    = (state == DCC_TRACK) && (cnt == CNT_W'(0));

  // ****************************************
  // Calibration engine
  // ****************************************
  // Sequence: fixed-line, then baseline drift, then tracking
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_dly_q = dly_q;
    next_trk_q = trk_q;
    next_drift_code = drift_code;
    case (state)
      DCC_IDLE: begin
        if (cal_start) begin
          next_state = DCC_FIXED;
          next_cnt   = CNT_W'(`DCC_FIX_CAL_CYC);
        end
      end
      DCC_FIXED: begin
        if (cnt == CNT_W'(0)) begin
          next_dly_q = 1'b1;
          next_state = DCC_VT;
          next_cnt   = CNT_W'(`DCC_VT_CAL_CYC);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      DCC_VT: begin
        // Baseline only runs once tracking is allowed
        if (drift_tracking_enable) begin
          if (cnt == CNT_W'(0)) begin
            next_trk_q = 1'b1;
            next_state = DCC_TRACK;
            next_cnt   = CNT_W'(`DCC_TRACK_PERIOD);
          end else begin
            next_cnt = cnt - CNT_W'(1);
          end
        end
      end
      DCC_TRACK: begin
        if (!drift_tracking_enable) begin
          next_trk_q = 1'b0;
          next_state = DCC_VT;
          next_cnt   = CNT_W'(`DCC_VT_CAL_CYC);
        end else if (cnt == CNT_W'(0)) begin
          // Periodic compensation keeps time-mode delay steady
          next_drift_code = drift_code + `DCC_ONE16;
          next_cnt = CNT_W'(`DCC_TRACK_PERIOD);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: next_state = DCC_IDLE;
    endcase
  end

  // ****************************************
  // Register port access and collisions
  // ****************************************
  // Fabric write colliding with engine write is held in a shadow
  always_comb begin
    next_drift_tracking_enable = drift_tracking_enable;
    next_cal_start = cal_start;
    next_regport_address = regport_address;
    next_shadow = shadow;
    next_pend = pend;
    next_coll = coll;
    next_ok_q = ok_q;
    next_regport_read_bus = riu_read(regport_address, st, drift_code);
    if (apb_wr && paddr == `DCC_REG_CTRL) begin
      next_drift_tracking_enable = pwdata[`DCC_CTRL_TRACK_BIT];
      next_cal_start = pwdata[`DCC_CTRL_CAL_BIT];
    end else if (apb_wr && paddr == `DCC_REG_PORT_ADDR) begin
      next_regport_address = pwdata[5:0];
    end else if (apb_wr && paddr == `DCC_REG_PORT_WDAT && ok_q) begin
      next_shadow = pwdata[15:0];
      next_pend = 1'b1;
    end
    if (pend) begin
      if (eng_wr && regport_address == `DCC_RIU_DRIFT_ADDR) begin
        next_ok_q = 1'b0;
        next_coll = 2'(`DCC_COLL_CYC);
      end else if (coll != 2'h0) begin
        next_coll = coll - 2'h1;
      end else begin
        next_pend = 1'b0;
        next_ok_q = 1'b1;
      end
    end
  end

  // Fabric write lands after engine write; port writes made while ok_q is low are dropped
  always_comb begin
    next_drift_code_fab = next_drift_code;
    if (pend && coll == 2'h0 && !eng_wr && regport_address == `DCC_RIU_DRIFT_ADDR) begin
      next_drift_code_fab = shadow;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Zero-wait answer; unmapped addresses give pslverr
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = apb_setup;
    next_pslverr = 1'b0;
    if (apb_setup) begin
      if (paddr == `DCC_REG_CTRL) begin
        next_prdata = {30'h0, cal_start, drift_tracking_enable};
      end else if (paddr == `DCC_REG_STATUS) begin
        next_prdata = {29'h0, ok_q, trk_q, dly_q};
      end else if (paddr == `DCC_REG_PORT_ADDR) begin
        next_prdata = {26'h0, regport_address};
      end else if (paddr == `DCC_REG_PORT_WDAT) begin
        next_prdata = {16'h0000, shadow};
      end else if (paddr == `DCC_REG_PORT_RDAT) begin
        next_prdata = {16'h0000, regport_read_bus};
      end else if (paddr == `DCC_REG_DRIFT) begin
        next_prdata = {16'h0000, drift_code};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Asynchronous clear of all calibration state; one port clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCC_IDLE;
      cnt <= '0;
      drift_tracking_enable <= 1'b0;
      cal_start <= 1'b0;
      regport_address <= 6'h00;
      regport_read_bus <= 16'h0000;
      drift_code <= 16'h0000;
      shadow <= 16'h0000;
      coll <= 2'h0;
      pend <= 1'b0;
      dly_q <= 1'b0;
      trk_q <= 1'b0;
      ok_q <= 1'b1;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      delay_calibrated <= 1'b0;
      tracking_ready <= 1'b0;
      regport_access_ok <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      drift_tracking_enable <= next_drift_tracking_enable;
      cal_start <= next_cal_start;
      regport_address <= next_regport_address;
      regport_read_bus <= next_regport_read_bus;
      drift_code <= next_drift_code_fab;
      shadow <= next_shadow;
      coll <= next_coll;
      pend <= next_pend;
      dly_q <= next_dly_q;
      trk_q <= next_trk_q;
      ok_q <= next_ok_q;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      delay_calibrated <= next_dly_q;
      tracking_ready <= next_trk_q;
      regport_access_ok <= next_ok_q;
    end
  end

endmodule : dcc_top

//--- sim/dcc_checker_assertions.sv
`timescale 1ns/1ps
`include "dcc_defs.svh"

// ****************************************
// Port checker
// ****************************************
module dcc_checker (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status side
  input wire logic        delay_calibrated,
  input wire logic        tracking_ready,
  input wire logic        regport_access_ok
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup of a control write that turns tracking off
  wire trk_off = psel && !penable && pwrite && paddr == `DCC_REG_CTRL && !pwdata[0];

  a_reset_clear: assert property (
    $rose(presetn) |-> !delay_calibrated && !tracking_ready) else $error("status not cleared");
  a_answer_next: assert property (
    psel && !penable |=> pready && penable) else $error("no answer after setup");
  a_answer_once: assert property (
    pready |=> !pready) else $error("ready held too long");
  a_status_view: assert property (
    pready && !pwrite && paddr == `DCC_REG_STATUS |-> prdata[2:0] == {$past(regport_access_ok),
    $past(tracking_ready), $past(delay_calibrated)}) else $error("status bits differ");
  a_trk_order: assert property (
    tracking_ready |-> delay_calibrated) else $error("tracking before calibration");
  a_dly_stays: assert property (
    delay_calibrated |=> delay_calibrated) else $error("calibrated flag dropped");
  a_trk_drop: assert property (
    $fell(tracking_ready) |-> $past(trk_off) || $past(trk_off, 2) || $past(trk_off, 3))
    else $error("tracking ready fell without cause");
  a_ok_back: assert property (
    $fell(regport_access_ok) |-> ##[1:8] regport_access_ok) else $error("access ok stuck low");
  a_upper_zero: assert property (
    pready && !pwrite && paddr == `DCC_REG_PORT_RDAT |-> prdata[31:16] == 16'h0000)
    else $error("port read upper bits set");
endmodule : dcc_checker

bind dcc_top dcc_checker dcc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .delay_calibrated(delay_calibrated),
  .tracking_ready(tracking_ready), .regport_access_ok(regport_access_ok));

//--- sim/dcc_fabric_model.sv
`timescale 1ns/1ps

// ****************************************
// Fabric side bus master
// ****************************************
module dcc_fabric_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic timed_out;
  // Idle bus at time zero, address zero until the first transfer
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timed_out = 1'b0;
  end
  // One transfer, synchronous to the clock; an idle cycle follows
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    timed_out = (k >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : dcc_fabric_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "dcc_defs.svh"

// ****************************************
// Testbench
// ****************************************
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, dly, trk, ok, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d0;
  int          num_errors, tests_run, n;
  logic [1:0]  dly_s, trk_s;

  // Free running 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  // Two-flop view of the status pins, as fabric logic would take them
  always @(posedge pclk) begin
    dly_s <= {dly_s[0], dly};
    trk_s <= {trk_s[0], trk};
  end

  dcc_top dcc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .delay_calibrated(dly), .tracking_ready(trk), .regport_access_ok(ok));
  dcc_fabric_model dcc_fabric_model_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Bus access; a hung bus ends the run
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    dcc_fabric_model_i.xfer(w, a, d, rd, err);
    if (dcc_fabric_model_i.timed_out) begin
      num_errors++;
      summarize();
    end
  endtask : rw
  // Bounded wait for a synchronised status level, cycles taken in n
  task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
    n = 0;
    while ((sel ? trk_s[1] : dly_s[1]) !== lvl && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if ((sel ? trk_s[1] : dly_s[1]) !== lvl) begin
      num_errors++;
      summarize();
    end
  endtask : wait_lvl

  task automatic t_reset;
    repeat (3) @(posedge pclk);
    chk({dly, trk, ok}, 32'h1);
    presetn <= 1'b1;
    rw(1'b0, `DCC_REG_STATUS, 32'h0);
    chk(rd, 32'h4);
    rw(1'b0, 12'h018, 32'h0);
    chk(err, 1'b1);
  endtask : t_reset
  task automatic t_cal;
    rw(1'b1, `DCC_REG_CTRL, 32'h2);
    wait_lvl(1'b0, 1'b1, 200);
    chk(n >= `DCC_FIX_CAL_CYC && n <= `DCC_FIX_CAL_CYC + 6, 1'b1);
    chk(trk, 1'b0);
    rw(1'b1, `DCC_REG_CTRL, 32'h3);
    wait_lvl(1'b1, 1'b1, 300);
    chk(n >= `DCC_VT_CAL_CYC && n <= `DCC_VT_CAL_CYC + 6, 1'b1);
    rw(1'b0, `DCC_REG_STATUS, 32'h0);
    chk(rd, 32'h7);
  endtask : t_cal
  task automatic t_drift;
    rw(1'b0, `DCC_REG_DRIFT, 32'h0);
    d0 = rd;
    repeat (40) @(posedge pclk);
    rw(1'b0, `DCC_REG_DRIFT, 32'h0);
    chk(rd !== d0, 1'b1);
    rw(1'b1, `DCC_REG_PORT_ADDR, 32'h0);
    rw(1'b0, `DCC_REG_PORT_RDAT, 32'h0);
    chk(rd[1:0], 2'b11);
    rw(1'b1, `DCC_REG_PORT_ADDR, 32'h1);
    rw(1'b0, `DCC_REG_PORT_RDAT, 32'h0);
    chk(rd[31:16], 16'h0000);
  endtask : t_drift
  // Port write against an engine write: access_ok dips, the write still lands
  task automatic t_coll;
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      rw(1'b1, `DCC_REG_PORT_WDAT, 32'h5A5A);
      @(posedge pclk);
      @(negedge pclk);
      hit = (ok === 1'b0);
    end
    chk(hit, 1'b1);
    n = 0;
    while (ok !== 1'b1 && n < 8) begin
      @(negedge pclk);
      n++;
    end
    chk(ok, 1'b1);
    if (ok !== 1'b1) begin
      summarize();
    end
    rw(1'b0, `DCC_REG_DRIFT, 32'h0);
    chk(rd, 32'h5A5A);
    rw(1'b0, `DCC_REG_PORT_WDAT, 32'h0);
    chk(rd, 32'h5A5A);
  endtask : t_coll
  task automatic t_off;
    rw(1'b1, `DCC_REG_CTRL, 32'h2);
    wait_lvl(1'b1, 1'b0, 6);
    chk(dly, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk({dly, trk}, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b0, `DCC_REG_STATUS, 32'h0);
    chk(rd, 32'h4);
  endtask : t_off

  // Main sequence
  initial begin
    presetn = 1'b0;
    num_errors = 0;
    tests_run = 0;
    t_reset();
    t_cal();
    t_drift();
    t_coll();
    t_off();
    summarize();
  end
endmodule : tb_top
